// ### logic/twm_pkg.sv
// Purpose: shared constants for the two-wire master transmitter
// Assumes: 125 MHz system clock, open-drain bus pins
// Notes:   codes are code_reg values, read in status bits 7 to 3 above the prescaler bits
// How it works
// - on finishing a start or byte, set done flag and hold clock line low until cleared; arbitration loss sets it with the clock line released.
// - writing one to the done flag clears it and launches the commanded operation.
// - status code read masked with 0xF8; codes defined with prescaler bits zero.
// - four modes exist: master transmit, master receive, slave transmit, slave receive; the code implements only the two master modes.
// - read bit high, write bit low; ack low, nack high; bytes are eight bits.
// - master mode only after start; address direction bit picks transmit or receive.
// - start command waits for a free bus, then generates the start.
// - start sent sets done flag with status 0x08.
// - address-write sent: status 0x18 ack, 0x20 nack, 0x38 arbitration lost.
// - data write while done flag low is dropped and sets write collision.
// - data byte sent: status 0x28 on ack, 0x30 on nack.
// - continue with no start or stop transmits the loaded byte and samples ack.
// - stop command sends stop, then hardware clears the stop request bit.
// - start plus stop command sends stop then start, clearing the stop request.
// - start during a transfer sends repeated start and reports status 0x10.
// - after 0x10 an address with read bit switches to master receive mode.
// - after 0x38, no start releases bus; start waits for free bus.
// - no done flag after a stop has been sent.
// - low two status bits are a read/write prescaler select, masked for codes.
// - interrupt request only when done flag, irq enable and global enable set.
package twm_pkg;
  localparam int unsigned CB_FLAG = 7;
  localparam int unsigned CB_ACK  = 6;
  localparam int unsigned CB_STA  = 5;
  localparam int unsigned CB_STO  = 4;
  localparam int unsigned CB_WC   = 3;
  localparam int unsigned CB_EN   = 2;
  localparam int unsigned CB_IRQ  = 0;
  localparam logic [7:0] CODE_MASK  = 8'hf8;
  localparam logic [4:0] ST_START_C = 5'h01;
  localparam logic [4:0] ST_RSTART  = 5'h02;
  localparam logic [4:0] ST_AW_ACK  = 5'h03;
  localparam logic [4:0] ST_AW_NACK = 5'h04;
  localparam logic [4:0] ST_DW_ACK  = 5'h05;
  localparam logic [4:0] ST_DW_NACK = 5'h06;
  localparam logic [4:0] ST_ARB     = 5'h07;
  localparam logic [4:0] ST_AR_ACK  = 5'h08;
  localparam logic [4:0] ST_AR_NACK = 5'h09;
  localparam logic [4:0] ST_DR_ACK  = 5'h0a;
  localparam logic [4:0] ST_DR_NACK = 5'h0b;
  localparam logic [4:0] ST_NONE    = 5'h1f;
  localparam logic [7:0] DATA_RST   = 8'hff;
  localparam logic [1:0] PRESC_RST  = 2'h0;
  localparam int unsigned CLK_MHZ   = 125;
  localparam int unsigned QTR_NS    = 2500;
  localparam int unsigned QTR_CYC   = (QTR_NS * CLK_MHZ) / 1000;
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned FIFO_W    = 8;
  localparam int unsigned FIFO_D    = 8;
  typedef enum logic [2:0] {
    FSM_IDLE  = 3'h0,
    FSM_WAIT  = 3'h1,
    FSM_START = 3'h2,
    FSM_BIT   = 3'h3,
    FSM_STOP  = 3'h4,
    FSM_HOLD  = 3'h5
  } twm_fsm_t;
  typedef enum logic [1:0] {
    MODE_MT = 2'h0,
    MODE_MR = 2'h1,
    MODE_ST = 2'h2,
    MODE_SR = 2'h3
  } twm_mode_t;
endpackage

// ### logic/twm_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs idle high
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module twm_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
      q_o    <= '1;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q_o <= s3_reg;
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/twm_fifo.sv
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   one extra pointer bit tells full from empty
`timescale 1ns/1ps
`default_nettype none
module twm_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
  assign out_valid_o = (wr_reg != rd_reg);
  assign out_data_o  = mem[rd_reg[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/twm_master.sv
// Purpose: two-wire bus master transmitter with command/status sequencing
// Assumes: software keeps the command protocol; bus lines are open drain
// Notes:   every byte seen on the bus, except one lost to arbitration, is also queued on the receive stream
`timescale 1ns/1ps
`default_nettype none
module twm_master #(
  parameter int unsigned QTR_CYC_P = twm_pkg::QTR_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       ctrl_wr_i,
  input  wire logic [7:0] ctrl_wdata_i,
  output logic      [7:0] ctrl_o,
  input  wire logic       presc_wr_i,
  input  wire logic [1:0] presc_wdata_i,
  output logic      [7:0] status_o,
  input  wire logic       data_wr_i,
  input  wire logic [7:0] data_wdata_i,
  output logic      [7:0] data_o,
  input  wire logic       global_irq_en_i,
  output logic            irq_o,
  output logic      [1:0] mode_o,
  output logic            rx_valid_o,
  input  wire logic       rx_ready_i,
  output logic      [7:0] rx_data_o,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_n_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o
);
  twm_pkg::twm_fsm_t  state_reg;
  twm_pkg::twm_mode_t mode_reg;
  logic [1:0]  phase_reg;
  logic [3:0]  bit_cnt_reg;
  logic [15:0] cnt_reg;
  logic [15:0] qtr_lim;
  logic        tick;
  logic        scl_s;
  logic        sda_s;
  logic        sda_q_reg;
  logic        busy_reg;
  logic        scl_low_reg;
  logic        sda_low_reg;
  logic [7:0]  shift_reg;
  logic        in_xfer_reg;
  logic        is_addr_reg;
  logic        lost_reg;
  logic        ack_seen_reg;
  logic        ack_drive_reg;
  logic        rx_phase_reg;
  logic        flag_reg;
  logic        ack_en_reg;
  logic        sta_reg;
  logic        sto_reg;
  logic        wc_reg;
  logic        en_reg;
  logic        irq_en_reg;
  logic [1:0]  presc_reg;
  logic [4:0]  code_reg;
  logic        launch;
  logic        flag_clr;
  logic        fin_start;
  logic        fin_byte;
  logic        fin_stop;
  logic        fin_lost;
  logic        arb_loss;
  logic        push_byte;
  logic        fifo_ready;
  logic        tx_bit;

  twm_sync #(
    .W (2)
  ) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({scl_i, sda_i}),
    .q_o    ({scl_s, sda_s})
  );

  twm_fifo #(
    .WIDTH (twm_pkg::FIFO_W),
    .DEPTH (twm_pkg::FIFO_D)
  ) u_fifo (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (push_byte),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({shift_reg[6:0], sda_s}),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o)
  );

  // quarter-bit enable pulse, scaled by the prescaler select
  assign qtr_lim = 16'(QTR_CYC_P) << {presc_reg, 1'b0};
  assign tick    = (cnt_reg == 16'h0000);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= 16'h0000;
    end else if (tick) begin
      cnt_reg <= qtr_lim - 16'h0001;
    end else begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end

  // bus monitor: start and stop seen on the synchronised lines
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sda_q_reg <= 1'b1;
      busy_reg  <= 1'b0;
    end else begin
      sda_q_reg <= sda_s;
      if (scl_s && sda_q_reg && !sda_s) begin
        busy_reg <= 1'b1;
      end else if (scl_s && !sda_q_reg && sda_s) begin
        busy_reg <= 1'b0;
      end
    end
  end

  assign flag_clr  = ctrl_wr_i && ctrl_wdata_i[twm_pkg::CB_FLAG] && flag_reg;
  // a command only runs with enable set and the done flag written as one
  assign launch    = ctrl_wr_i && ctrl_wdata_i[twm_pkg::CB_FLAG]
                     && ctrl_wdata_i[twm_pkg::CB_EN]
                     && ((state_reg == twm_pkg::FSM_HOLD)
                         || ((state_reg == twm_pkg::FSM_IDLE)
                             && ctrl_wdata_i[twm_pkg::CB_STA]));
  assign fin_start = en_reg && tick && (state_reg == twm_pkg::FSM_START) && (phase_reg == 2'h3);
  assign fin_stop  = en_reg && tick && (state_reg == twm_pkg::FSM_STOP) && (phase_reg == 2'h3);
  assign fin_byte  = en_reg && tick && (state_reg == twm_pkg::FSM_BIT) && (phase_reg == 2'h3)
                     && (bit_cnt_reg == 4'(twm_pkg::BYTE_BITS));
  // a released one read back as low means another master won
  assign arb_loss  = !rx_phase_reg && !sda_low_reg && !sda_s
                     && (bit_cnt_reg < 4'(twm_pkg::BYTE_BITS));
  assign fin_lost  = en_reg && tick && (state_reg == twm_pkg::FSM_BIT) && (phase_reg == 2'h2)
                     && arb_loss;
  assign push_byte = en_reg && tick && (state_reg == twm_pkg::FSM_BIT) && (phase_reg == 2'h2)
                     && !arb_loss && (bit_cnt_reg == 4'(twm_pkg::BYTE_BITS - 1));
  // ack slot: receiver drives ack low when enabled, transmitter releases
  assign tx_bit    = (bit_cnt_reg < 4'(twm_pkg::BYTE_BITS)) ? (rx_phase_reg || shift_reg[7])
                     : !(rx_phase_reg && ack_drive_reg);

  // bus sequencer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg     <= twm_pkg::FSM_IDLE;
      phase_reg     <= 2'h0;
      bit_cnt_reg   <= 4'h0;
      scl_low_reg   <= 1'b0;
      sda_low_reg   <= 1'b0;
      in_xfer_reg   <= 1'b0;
      is_addr_reg   <= 1'b0;
      lost_reg      <= 1'b0;
      ack_seen_reg  <= 1'b0;
      ack_drive_reg <= 1'b0;
      rx_phase_reg  <= 1'b0;
      mode_reg      <= twm_pkg::MODE_SR;
    end else if (!en_reg) begin
      state_reg   <= twm_pkg::FSM_IDLE;
      phase_reg   <= 2'h0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      in_xfer_reg <= 1'b0;
      lost_reg    <= 1'b0;
      mode_reg    <= twm_pkg::MODE_SR;
      if (launch) begin
        state_reg <= twm_pkg::FSM_WAIT;
      end
    end else begin
      case (state_reg)
        twm_pkg::FSM_IDLE: begin
          if (launch) begin
            state_reg <= twm_pkg::FSM_WAIT;
          end
        end
        twm_pkg::FSM_WAIT: begin
          if (!busy_reg && tick) begin
            state_reg <= twm_pkg::FSM_START;
            phase_reg <= 2'h0;
          end
        end
        twm_pkg::FSM_HOLD: begin
          if (launch) begin
            phase_reg     <= 2'h0;
            bit_cnt_reg   <= 4'h0;
            ack_drive_reg <= ctrl_wdata_i[twm_pkg::CB_ACK];
            rx_phase_reg  <= (mode_reg == twm_pkg::MODE_MR) && !is_addr_reg;
            if (lost_reg) begin
              lost_reg  <= 1'b0;
              state_reg <= ctrl_wdata_i[twm_pkg::CB_STA] ? twm_pkg::FSM_WAIT
                                                        : twm_pkg::FSM_IDLE;
            end else if (ctrl_wdata_i[twm_pkg::CB_STO]) begin
              state_reg <= twm_pkg::FSM_STOP;
            end else if (ctrl_wdata_i[twm_pkg::CB_STA]) begin
              state_reg <= twm_pkg::FSM_START;
            end else begin
              state_reg <= twm_pkg::FSM_BIT;
            end
          end
        end
        twm_pkg::FSM_START: begin
          if (tick) begin
            case (phase_reg)
              2'h0: begin
                sda_low_reg <= 1'b0;
                phase_reg   <= 2'h1;
              end
              2'h1: begin
                scl_low_reg <= 1'b0;
                if (scl_s) begin
                  phase_reg <= 2'h2;
                end
              end
              2'h2: begin
                sda_low_reg <= 1'b1;
                phase_reg   <= 2'h3;
              end
              default: begin
                scl_low_reg <= 1'b1;
                in_xfer_reg <= 1'b1;
                is_addr_reg <= 1'b1;
                state_reg   <= twm_pkg::FSM_HOLD;
              end
            endcase
          end
        end
        twm_pkg::FSM_BIT: begin
          if (tick) begin
            case (phase_reg)
              2'h0: begin
                if ((bit_cnt_reg != 4'h0) || fifo_ready) begin
                  sda_low_reg <= !tx_bit;
                  phase_reg   <= 2'h1;
                end
              end
              2'h1: begin
                scl_low_reg <= 1'b0;
                if (scl_s) begin
                  phase_reg <= 2'h2;
                end
              end
              2'h2: begin
                if (arb_loss) begin
                  sda_low_reg <= 1'b0;
                  in_xfer_reg <= 1'b0;
                  lost_reg    <= 1'b1;
                  mode_reg    <= twm_pkg::MODE_SR;
                  state_reg   <= twm_pkg::FSM_HOLD;
                end else begin
                  if (bit_cnt_reg == 4'(twm_pkg::BYTE_BITS)) begin
                    ack_seen_reg <= !sda_s;
                  end
                  phase_reg <= 2'h3;
                end
              end
              default: begin
                scl_low_reg <= 1'b1;
                if (bit_cnt_reg == 4'(twm_pkg::BYTE_BITS)) begin
                  sda_low_reg <= 1'b0;
                  state_reg   <= twm_pkg::FSM_HOLD;
                  if (is_addr_reg) begin
                    is_addr_reg <= 1'b0;
                    mode_reg    <= shift_reg[0] ? twm_pkg::MODE_MR : twm_pkg::MODE_MT;
                  end
                end else begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  phase_reg   <= 2'h0;
                end
              end
            endcase
          end
        end
        twm_pkg::FSM_STOP: begin
          if (tick) begin
            case (phase_reg)
              2'h0: begin
                sda_low_reg <= 1'b1;
                phase_reg   <= 2'h1;
              end
              2'h1: begin
                scl_low_reg <= 1'b0;
                if (scl_s) begin
                  phase_reg <= 2'h2;
                end
              end
              2'h2: begin
                sda_low_reg <= 1'b0;
                phase_reg   <= 2'h3;
              end
              default: begin
                in_xfer_reg <= 1'b0;
                mode_reg    <= twm_pkg::MODE_SR;
                phase_reg   <= 2'h0;
                state_reg   <= sta_reg ? twm_pkg::FSM_WAIT : twm_pkg::FSM_IDLE;
              end
            endcase
          end
        end
        default: begin
          state_reg <= twm_pkg::FSM_IDLE;
        end
      endcase
    end
  end

  // shift register: loaded by software, shifted with the bus
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_reg <= twm_pkg::DATA_RST;
    end else if (en_reg && tick && (state_reg == twm_pkg::FSM_BIT) && (phase_reg == 2'h2)
                 && (bit_cnt_reg < 4'(twm_pkg::BYTE_BITS))) begin
      shift_reg <= {shift_reg[6:0], sda_s};
    end else if (data_wr_i && flag_reg) begin
      shift_reg <= data_wdata_i;
    end
  end

  // control register bits
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_reg   <= 1'b0;
      ack_en_reg <= 1'b0;
      sta_reg    <= 1'b0;
      sto_reg    <= 1'b0;
      wc_reg     <= 1'b0;
      en_reg     <= 1'b0;
      irq_en_reg <= 1'b0;
    end else begin
      if (fin_start || fin_byte || fin_lost) begin
        flag_reg <= 1'b1;
      end else if (flag_clr) begin
        flag_reg <= 1'b0;
      end
      if (ctrl_wr_i) begin
        ack_en_reg <= ctrl_wdata_i[twm_pkg::CB_ACK];
        sta_reg    <= ctrl_wdata_i[twm_pkg::CB_STA];
        en_reg     <= ctrl_wdata_i[twm_pkg::CB_EN];
        irq_en_reg <= ctrl_wdata_i[twm_pkg::CB_IRQ];
      end
      if (fin_stop) begin
        sto_reg <= 1'b0;
      end else if (ctrl_wr_i) begin
        sto_reg <= ctrl_wdata_i[twm_pkg::CB_STO];
      end
      if (data_wr_i) begin
        wc_reg <= !flag_reg;
      end
    end
  end

  // status code and prescaler select
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      code_reg  <= twm_pkg::ST_NONE;
      presc_reg <= twm_pkg::PRESC_RST;
    end else begin
      if (presc_wr_i) begin
        presc_reg <= presc_wdata_i;
      end
      if (fin_start) begin
        code_reg <= in_xfer_reg ? twm_pkg::ST_RSTART : twm_pkg::ST_START_C;
      end else if (fin_lost) begin
        code_reg <= twm_pkg::ST_ARB;
      end else if (fin_byte) begin
        if (is_addr_reg && shift_reg[0]) begin
          code_reg <= ack_seen_reg ? twm_pkg::ST_AR_ACK : twm_pkg::ST_AR_NACK;
        end else if (is_addr_reg) begin
          code_reg <= ack_seen_reg ? twm_pkg::ST_AW_ACK : twm_pkg::ST_AW_NACK;
        end else if (rx_phase_reg) begin
          code_reg <= ack_drive_reg ? twm_pkg::ST_DR_ACK : twm_pkg::ST_DR_NACK;
        end else begin
          code_reg <= ack_seen_reg ? twm_pkg::ST_DW_ACK : twm_pkg::ST_DW_NACK;
        end
      end else if (fin_stop || (state_reg == twm_pkg::FSM_IDLE && !flag_reg)) begin
        code_reg <= twm_pkg::ST_NONE;
      end
    end
  end

  // register views and pins
  assign ctrl_o     = {flag_reg, ack_en_reg, sta_reg, sto_reg,
                       wc_reg, en_reg, 1'b0, irq_en_reg};
  assign status_o   = {code_reg, 1'b0, presc_reg};
  assign data_o     = shift_reg;
  assign mode_o     = mode_reg;
  assign irq_o      = flag_reg && irq_en_reg && global_irq_en_i;
  assign scl_o      = 1'b0;
  assign sda_o      = 1'b0;
  assign scl_oe_n_o = !scl_low_reg;
  assign sda_oe_n_o = !sda_low_reg;
endmodule
`default_nettype wire

// ### dv/twm_slave.sv
// Purpose: behavioural slave receiver on the two-wire bus
// Assumes: open-drain lines with pull-ups
// Notes:   lose_i acts as a rival master pulling data low in bit 0
`timescale 1ns/1ps
`default_nettype none
module twm_slave (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       nack_i,
  input  wire logic       lose_i,
  input  wire logic       stretch_i,
  output logic            scl_pull_o,
  output logic            sda_pull_o,
  output logic      [7:0] byte_o
);
  logic       act = 1'b0;
  logic [3:0] cnt = 4'h0;
  initial byte_o = 8'h00;
  initial scl_pull_o = 1'b0;
  // start and stop seen with the clock line high
  always @(negedge sda_i) begin
    if (scl_i) begin
      act = 1'b1;
      cnt = 4'hf;
    end
  end
  always @(posedge sda_i) begin
    if (scl_i) begin
      act = 1'b0;
    end
  end
  always @(negedge scl_i) begin
    if (act) begin
      cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
    end
  end
  always @(posedge scl_i) begin
    if (act && cnt < 4'h8) begin
      byte_o = {byte_o[6:0], sda_i};
    end
  end
  // slow answer: hold the clock low for 80 ns, ten clock periods
  always @(negedge scl_i) begin
    if (stretch_i) begin
      scl_pull_o = 1'b1;
      #80;
      scl_pull_o = 1'b0;
    end
  end
  assign sda_pull_o = act && ((cnt == 4'h8 && !nack_i) || (cnt == 4'h0 && lose_i));
endmodule
`default_nettype wire

// ### dv/twm_master_props.sv
// Purpose: concurrent checks on the master's ports
// Assumes: prescaler select zero during stops
// Notes:   bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module twm_master_props #(
  parameter int unsigned QTR_CYC_P = 4
) (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       ctrl_wr_i,
  input wire logic [7:0] ctrl_wdata_i,
  input wire logic [7:0] ctrl_o,
  input wire logic [7:0] status_o,
  input wire logic       data_wr_i,
  input wire logic [7:0] data_wdata_i,
  input wire logic [7:0] data_o,
  input wire logic       global_irq_en_i,
  input wire logic       irq_o,
  input wire logic       scl_oe_n_o,
  input wire logic       sda_oe_n_o
);
  localparam int STOP_MAX = 15 * QTR_CYC_P;
  logic stop_cmd;
  assign stop_cmd = ctrl_wr_i && ctrl_o[7] && ctrl_wdata_i[7:4] == 4'h9;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  chk_scl_held: assert property (ctrl_o[7] && status_o[7:3] != 5'h07 |-> !scl_oe_n_o)
    else $error("clock line released");
  chk_flag_clear: assert property (
    ctrl_wr_i && ctrl_wdata_i[7] && ctrl_wdata_i[2] && ctrl_o[7] |=> !ctrl_o[7])
    else $error("flag not cleared");
  chk_wc_set: assert property (data_wr_i && !ctrl_o[7] |=> ctrl_o[3])
    else $error("collision not flagged");
  chk_data_load: assert property (
    data_wr_i && ctrl_o[7] |=> data_o == $past(data_wdata_i) && !ctrl_o[3])
    else $error("data not loaded");
  chk_fixed_bits: assert property (!status_o[2] && !ctrl_o[1])
    else $error("fixed bits set");
  chk_irq_gate: assert property (irq_o == (ctrl_o[7] && ctrl_o[0] && global_irq_en_i))
    else $error("irq gating wrong");
  chk_stop_noflag: assert property (stop_cmd |=> !ctrl_o[7] throughout (##STOP_MAX 1'b1))
    else $error("flag after stop");
  chk_stop_clear: assert property (stop_cmd |-> ##[1:STOP_MAX] !ctrl_o[4])
    else $error("stop request kept");
  chk_idle_off: assert property (
    !ctrl_o[2] && !$past(ctrl_o[2]) |-> scl_oe_n_o && sda_oe_n_o)
    else $error("bus driven while disabled");
  chk_code_set: assert property (ctrl_o[7] |-> status_o[7:3] != 5'h1f)
    else $error("no code with flag");
  cover property ($rose(ctrl_o[7]) && status_o[7:3] == 5'h07);
  cover property (stop_cmd);
  cover property (irq_o);
endmodule
`default_nettype wire

// ### dv/test_twm_master.sv
// Purpose: directed bench for the two-wire master
// Assumes: quarter bit of 4 cycles
// Notes:   receive stream checked in the background
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module test_twm_master;
  logic       clk_i = 1'b0, rstn_i = 1'b0, ctrl_wr_i = 1'b0, presc_wr_i = 1'b0;
  logic       data_wr_i = 1'b0, global_irq_en_i = 1'b0, rx_ready_i = 1'b0;
  logic [7:0] ctrl_wdata_i = 8'h00, data_wdata_i = 8'h00, e, got;
  logic [1:0] presc_wdata_i = 2'h0, mode_o;
  logic [7:0] ctrl_o, status_o, data_o, rx_data_o, s_byte;
  logic       irq_o, rx_valid_o, scl_o, sda_o, scl_oe_n_o, sda_oe_n_o, s_scl, s_sda;
  logic       nack = 1'b0, lose = 1'b0, strch = 1'b0;
  wire logic  scl_i = !((!scl_oe_n_o && !scl_o) || s_scl);
  wire logic  sda_i = !((!sda_oe_n_o && !sda_o) || s_sda);
  logic [7:0] exp_q[$];
  int         n_fail = 0;
  int         total_checks = 0;
  twm_master #(.QTR_CYC_P(4)) u_dut (.*);
  twm_slave u_slave (.scl_i(scl_i), .sda_i(sda_i), .nack_i(nack), .lose_i(lose),
    .stretch_i(strch), .scl_pull_o(s_scl), .sda_pull_o(s_sda), .byte_o(s_byte));
  initial forever #4 clk_i = ~clk_i;
  // sel 0 control, 1 data, 2 prescaler
  task automatic wr(input logic [1:0] sel, input logic [7:0] v);
    @(posedge clk_i);
    ctrl_wr_i <= sel == 2'h0;
    data_wr_i <= sel == 2'h1;
    presc_wr_i <= sel == 2'h2;
    ctrl_wdata_i <= v;
    data_wdata_i <= v;
    presc_wdata_i <= v[1:0];
    @(posedge clk_i);
    {ctrl_wr_i, data_wr_i, presc_wr_i} <= 3'h0;
  endtask
  task automatic op(input logic [7:0] c, input logic [7:0] code, input logic st);
    int k;
    wr(2'h0, c);
    if (st) begin
      repeat (400) @(posedge clk_i);
      `CHK(ctrl_o[7], 1'b0)
      rx_ready_i <= 1'b1;
    end
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (ctrl_o[7] !== 1'b1 && k < 3000);
    `CHK(ctrl_o[7], 1'b1)
    `CHK(status_o & 8'hf8, code)
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(negedge clk_i) begin
    if (rx_valid_o === 1'b1 && rx_ready_i) begin
      got = exp_q.pop_front();
      `CHK(rx_data_o, got)
    end
  end
  initial begin
    #300000;
    n_fail++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(negedge clk_i);
    `CHK({ctrl_o, status_o, data_o}, 24'h00f8ff)
    `CHK({irq_o, scl_oe_n_o, sda_oe_n_o, mode_o}, 5'h0f)
    wr(2'h2, 8'h03);
    @(negedge clk_i);
    `CHK(status_o, 8'hfb)
    wr(2'h2, 8'h00);
    wr(2'h1, 8'h55);
    @(negedge clk_i);
    `CHK({ctrl_o[3], data_o}, 9'h1ff)
    global_irq_en_i <= 1'b1;
    op(8'ha5, 8'h08, 1'b0);
    `CHK({irq_o, scl_oe_n_o}, 2'h2)
    global_irq_en_i <= 1'b0;
    @(negedge clk_i);
    `CHK(irq_o, 1'b0)
    wr(2'h1, 8'ha0);
    exp_q.push_back(8'ha0);
    op(8'h84, 8'h18, 1'b0);
    `CHK({mode_o, s_byte, ctrl_o[3]}, 11'h140)
    for (int i = 0; i < 8; i++) begin
      e = 8'h3c ^ 8'(i);
      nack <= (i == 7);
      strch <= (i == 1);
      wr(2'h1, e);
      exp_q.push_back(e);
      op(8'h84, (i == 7) ? 8'h30 : 8'h28, i == 7);
      `CHK(s_byte, e)
    end
    nack <= 1'b0;
    op(8'ha4, 8'h10, 1'b0);
    wr(2'h1, 8'ha1);
    exp_q.push_back(8'ha1);
    op(8'h84, 8'h40, 1'b0);
    `CHK(mode_o, 2'h1)
    wr(2'h0, 8'h94);
    repeat (100) @(negedge clk_i);
    `CHK({ctrl_o[7], ctrl_o[4], scl_i, sda_i}, 4'h3)
    op(8'ha4, 8'h08, 1'b0);
    op(8'hb4, 8'h08, 1'b0);
    `CHK(ctrl_o[4], 1'b0)
    wr(2'h0, 8'h94);
    repeat (100) @(posedge clk_i);
    lose <= 1'b1;
    op(8'ha4, 8'h08, 1'b0);
    wr(2'h1, 8'ha0);
    op(8'h84, 8'h38, 1'b0);
    lose <= 1'b0;
    wr(2'h0, 8'h84);
    repeat (40) @(negedge clk_i);
    `CHK({ctrl_o[7], mode_o, scl_i, sda_i}, 5'h0f)
    `CHK(exp_q.size(), 0)
    test_done();
  end
endmodule
bind twm_master twm_master_props #(.QTR_CYC_P(4)) u_props (.*);
`default_nettype wire
